//--- vss_regs.svh
// Purpose: offsets, field positions, reset values and counts of the sequencer
// Assumes: levels are counted in units of 12.5 mV
// Notes:   definitions only
`ifndef VSS_REGS_SVH
`define VSS_REGS_SVH

// ***************************************************
// register map (byte addresses)
// ***************************************************
`define VSS_CONTROL_ADDR 8'h00
`define VSS_STATUS_ADDR 8'h04
`define VSS_LEVEL_ADDR 8'h08
`define VSS_CONTROL_RESET 2'h1
`define VSS_MODE_LSB 0
`define VSS_STATE_LSB 0
`define VSS_CLAMP_BIT 2
`define VSS_DRIVE_BIT 3
`define VSS_GATE_OE_BIT 4
`define VSS_CODE_LSB 8
`define VSS_REF_LSB 0
`define VSS_TARGET_LSB 8
`define VSS_OVTH_LSB 16

// ***************************************************
// sequencing counts, in phase clock cycles or samples
// ***************************************************
`define VSS_SAMPLES_FIVE 4
`define VSS_SAMPLES_SIX 6
`define VSS_ACCEPT_READS 3
`define VSS_WAIT_CYCLES 16
`define VSS_RAMP_CYCLES 16
`define VSS_DVID_CYCLES 4

// ***************************************************
// levels, in 12.5 mV units, and the no-load code
// ***************************************************
`define VSS_RAMP_STEP 8'h01
`define VSS_DVID_STEP 8'h02
`define VSS_OV_MARGIN 9'h010
`define VSS_OV_FIXED_LOW 9'h084
`define VSS_OV_FIXED_HIGH 9'h09C
`define VSS_NO_LOAD 5'h1F

`endif

//--- vss_pkg.sv
// Purpose: types shared by the sequencer files
// Assumes: nothing
// Notes:   state codes follow a Gray path off, wait, ramp, run
package vss_pkg;
   typedef enum logic [1:0] {
      MODE_ALT_FIVE = 2'h0,
      MODE_FIVE = 2'h1,
      MODE_SIX = 2'h2
   } mode_type;

   typedef enum logic [1:0] {
      ST_OFF = 2'h0,
      ST_WAIT = 2'h1,
      ST_RAMP = 2'h3,
      ST_RUN = 2'h2
   } state_type;
endpackage

//--- sample_tick.sv
// Purpose: spreads a fixed number of sample ticks across one measured period
// Assumes: period is the last measured phase period in hclk cycles
// Notes:   a zero period gives no ticks
`timescale 1ns/10ps
`default_nettype none
module sample_tick #(
   parameter int PW = 10,
   parameter int N = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [PW-1:0] period,
   output logic tick
);
   generate
      if (N < 1 || N >= (1 << PW)) begin : g_bad
         $error("sample_tick: N does not fit the period width");
      end
   endgenerate

   logic [PW:0] acc_ff;
   logic [PW:0] nxt_acc;
   logic tick_ff;
   logic nxt_tick;
   logic [PW:0] sum;

   // ***************************************************
   // accumulate N per cycle, wrap on the period
   // ***************************************************
   always_comb begin
      sum = acc_ff + (PW+1)'(N);
      nxt_acc = sum;
      nxt_tick = 1'b0;
      if (period == '0) begin
         nxt_acc = '0;
      end else if (sum >= {1'b0, period}) begin
         nxt_acc = sum - {1'b0, period};
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule // sample_tick
`default_nettype wire

//--- vid_softstart_sequencer.sv
// Purpose: code sampling, reference stepping, start-up gating, soft-start and overvoltage clamp
// Assumes: comparator inputs and phase_clock are already synchronous to hclk
// Notes:   levels are 12.5 mV units; registers over AHB-Lite, zero wait states
//
// Summary of operation
// R1 - five-bit modes sample the code from the five code pins
// R2 - five-bit modes take four code samples per switching cycle
// R3 - a new code is accepted after three identical consecutive samples
// R4 - five-bit modes step reference 0.025 V every four cycles to target
// R5 - six-bit mode takes six code samples per switching cycle
// R6 - six-bit mode jumps the reference straight to the accepted code
// R7 - in six-bit mode the processor moves the code one step at a time
// R8 - below supply power-on level the low-side drivers are high impedance
// R9 - after power-on, feedback above 1.65 V or 1.95 V turns low sides on
// R10 - overvoltage level is max(fixed, target+200 mV) in soft-start, else target+200 mV; while off the code holds the fixed level
// R11 - clamp releases only when output falls below hysteresis, re-engages on new excursion
// R12 - overvoltage never latches the converter off
// R13 - below either power-on level all switches stay off; with only driver_supply_por_ok low the clamp still turns the low sides on
// R14 - all-ones code keeps the converter disabled; any other code starts it; the code checks only bits 5:1, so six-bit code 6'h3E also stays off
// R15 - soft-start begins once supplies, enable threshold and code allow it
// R16 - wait 16 phase cycles before the reference ramp starts
// R17 - ramp the reference 12.5 mV every 16 phase cycles up to target
// R18 - drivers stay off while feedback is above the ramping reference
// R19 - output pre-charged above target gets drivers at end of soft-start
// R20 - the code is decoded into one level by the selected table
// R21 - comparators arrive as single bits; ticks come from the phase clock
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "vss_regs.svh"
module vid_softstart_sequencer #(
   parameter int PW = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic phase_clock,
   input wire logic [4:0] code_select_pins,
   input wire logic code_extra_bit,
   input wire logic bias_por_ok,
   input wire logic driver_supply_por_ok,
   input wire logic threshold_enable_input,
   input wire logic feedback_above_ref,
   input wire logic feedback_above_ov,
   input wire logic feedback_below_hyst,
   output logic pwm_enable,
   output logic low_side_gate,
   output logic low_side_gate_oe,
   output logic [7:0] reference_level,
   output logic [8:0] overvoltage_guard_level
);
   import vss_pkg::*;

   generate
      if (PW < 4) begin : g_bad
         $error("vid_softstart_sequencer: PW too small for a phase period");
      end
   endgenerate

   // ***************************************************
   // register bus
   // ***************************************************
   mode_type mode_ff, nxt_mode;
   logic wr_pend_ff, nxt_wr_pend;
   logic [7:0] wr_addr_ff, nxt_wr_addr;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic [31:0] status_word;
   logic [31:0] level_word;
   logic addr_ok;

   state_type state_ff, nxt_state;
   logic [5:0] code_ff, nxt_code;
   logic [7:0] ref_ff, nxt_ref;
   logic [7:0] target;
   logic [8:0] ovth_ff, nxt_ovth;
   logic clamp_ff, nxt_clamp;
   logic drive_ff, nxt_drive;
   logic gate_oe_ff, nxt_gate_oe;

   assign addr_ok = hsel && htrans[1] && hready;
   assign status_word = {16'h0000, 2'h0, code_ff, 3'h0, gate_oe_ff, drive_ff, clamp_ff, state_ff};
   assign level_word = {7'h00, ovth_ff, target, ref_ff};

   always_comb begin
      nxt_mode = mode_ff;
      nxt_wr_pend = addr_ok && hwrite && hsize == 3'h2;
      nxt_wr_addr = haddr[7:0];
      nxt_hrdata = 32'h0000_0000;
      if (wr_pend_ff && wr_addr_ff == `VSS_CONTROL_ADDR && hwdata[1:0] != 2'h3) begin
         nxt_mode = mode_type'(hwdata[`VSS_MODE_LSB +: 2]);
      end
      // unmapped or non-word reads return zero, still OKAY
      if (addr_ok && !hwrite && hsize == 3'h2) begin
         case (haddr[7:0])
            `VSS_CONTROL_ADDR: nxt_hrdata = {30'h0, mode_ff};
            `VSS_STATUS_ADDR: nxt_hrdata = status_word;
            `VSS_LEVEL_ADDR: nxt_hrdata = level_word;
            default: nxt_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff <= mode_type'(`VSS_CONTROL_RESET);
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
      end else begin
         mode_ff <= nxt_mode;
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
         hrdata_ff <= nxt_hrdata;
      end
   end

   // ***************************************************
   // phase period and sample ticks
   // ***************************************************
   logic phase_prev_ff;
   logic phase_edge;
   logic [PW-1:0] pcount_ff, nxt_pcount;
   logic [PW-1:0] period_ff, nxt_period;
   logic tick_four, tick_six, samp_tick;
   logic six;

   assign phase_edge = phase_clock && !phase_prev_ff; // [R21]
   assign six = mode_ff == MODE_SIX;
   assign samp_tick = six ? tick_six : tick_four; // [R2] [R5]

   always_comb begin
      nxt_pcount = (pcount_ff == '1) ? pcount_ff : pcount_ff + 1'b1;
      nxt_period = period_ff;
      if (phase_edge) begin
         // latch the count before it restarts, else the period reads zero
         nxt_period = nxt_pcount;
         nxt_pcount = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_prev_ff <= 1'b0;
         pcount_ff <= '0;
         period_ff <= '0;
      end else begin
         phase_prev_ff <= phase_clock;
         pcount_ff <= nxt_pcount;
         period_ff <= nxt_period;
      end
   end

   sample_tick #(.PW(PW), .N(`VSS_SAMPLES_FIVE)) u_tick_four (
      .hclk(hclk),
      .hresetn(hresetn),
      .period(period_ff),
      .tick(tick_four)
   );

   sample_tick #(.PW(PW), .N(`VSS_SAMPLES_SIX)) u_tick_six (
      .hclk(hclk),
      .hresetn(hresetn),
      .period(period_ff),
      .tick(tick_six)
   );

   // ***************************************************
   // code sampling and acceptance
   // ***************************************************
   logic [5:0] sample;
   logic [5:0] last_ff, nxt_last;
   logic [1:0] same_ff, nxt_same;
   logic no_load;

   // the extra bit only counts in six-bit mode
   assign sample = {code_select_pins, six ? code_extra_bit : 1'b0}; // [R1]
   assign no_load = code_ff[5:1] == `VSS_NO_LOAD;

   always_comb begin
      nxt_last = last_ff;
      nxt_same = same_ff;
      nxt_code = code_ff;
      if (samp_tick) begin
         nxt_last = sample;
         if (sample != last_ff) begin
            nxt_same = 2'h0;
         end else if (same_ff < 2'(`VSS_ACCEPT_READS - 1)) begin
            nxt_same = same_ff + 2'h1;
         end
         // third matching read: one match already counted
         if (sample == last_ff && same_ff == 2'(`VSS_ACCEPT_READS - 2)) begin
            nxt_code = sample; // [R3]
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_ff <= 6'h3F;
         same_ff <= 2'h0;
         code_ff <= 6'h3F;
      end else begin
         last_ff <= nxt_last;
         same_ff <= nxt_same;
         code_ff <= nxt_code;
      end
   end

   // ***************************************************
   // code to level
   // ***************************************************
   function automatic logic [7:0] decode_level(input mode_type m, input logic [5:0] c);
      logic [7:0] k;
      k = {2'h0, c};
      if (c[5:1] == `VSS_NO_LOAD) begin
         decode_level = 8'h00;
      end else begin
         case (m)
            MODE_ALT_FIVE: decode_level = 8'h7C - {2'h0, c[5:1], 1'b0};
            MODE_FIVE: decode_level = 8'h94 - {2'h0, c[5:1], 1'b0};
            MODE_SIX: begin
               if (c >= 6'h15) begin
                  decode_level = 8'h95 - k;
               end else if (c != 6'h00) begin
                  decode_level = 8'h57 - k;
               end else begin
                  decode_level = 8'h56;
               end
            end
            default: decode_level = 8'h00;
         endcase
      end
   endfunction

   assign target = decode_level(mode_ff, code_ff); // [R20]

   // ***************************************************
   // sequencer, reference and protection
   // ***************************************************
   logic [3:0] cyc_ff, nxt_cyc;
   logic caught_ff, nxt_caught;
   logic por_ok;
   logic start_ok;
   logic [8:0] ov_fixed;
   logic [8:0] ov_track;

   assign por_ok = bias_por_ok && driver_supply_por_ok;
   assign start_ok = por_ok && threshold_enable_input && !no_load; // [R14] [R15]
   assign ov_fixed = (mode_ff == MODE_FIVE) ? `VSS_OV_FIXED_HIGH : `VSS_OV_FIXED_LOW; // [R9]
   assign ov_track = {1'b0, target} + `VSS_OV_MARGIN;

   always_comb begin
      nxt_state = state_ff;
      nxt_cyc = cyc_ff;
      nxt_ref = ref_ff;
      nxt_caught = caught_ff;
      case (state_ff)
         ST_OFF: begin
            nxt_ref = 8'h00;
            nxt_cyc = 4'h0;
            nxt_caught = 1'b0;
            if (start_ok) begin
               nxt_state = ST_WAIT; // [R15]
            end
         end
         ST_WAIT: begin
            if (phase_edge) begin
               nxt_cyc = cyc_ff + 4'h1;
               if (cyc_ff == 4'(`VSS_WAIT_CYCLES - 1)) begin
                  nxt_state = ST_RAMP; // [R16]
               end
            end
         end
         ST_RAMP: begin
            if (!feedback_above_ref) begin
               nxt_caught = 1'b1; // [R18]
            end
            if (ref_ff >= target) begin
               nxt_ref = target;
               nxt_state = ST_RUN;
               nxt_cyc = 4'h0;
            end else if (phase_edge) begin
               nxt_cyc = cyc_ff + 4'h1;
               if (cyc_ff == 4'(`VSS_RAMP_CYCLES - 1)) begin
                  nxt_ref = ref_ff + `VSS_RAMP_STEP; // [R17]
               end
            end
         end
         ST_RUN: begin
            if (six) begin
               nxt_ref = target; // [R6]
            end else if (phase_edge) begin
               nxt_cyc = (cyc_ff == 4'(`VSS_DVID_CYCLES - 1)) ? 4'h0 : cyc_ff + 4'h1;
               if (cyc_ff == 4'(`VSS_DVID_CYCLES - 1)) begin
                  // one 0.025 V step per four cycles, landing exactly on target
                  if (ref_ff + `VSS_DVID_STEP <= target) begin
                     nxt_ref = ref_ff + `VSS_DVID_STEP; // [R4]
                  end else if (ref_ff >= target + `VSS_DVID_STEP) begin
                     nxt_ref = ref_ff - `VSS_DVID_STEP; // [R4]
                  end else begin
                     nxt_ref = target;
                  end
               end
            end
         end
         default: nxt_state = ST_OFF;
      endcase
      if (!start_ok) begin
         nxt_state = ST_OFF;
      end
   end

   // clamp is independent of the sequencer so an event never returns it to off; it only masks the drivers while set
   always_comb begin
      nxt_gate_oe = bias_por_ok; // [R8]
      nxt_ovth = ov_fixed;
      if (state_ff == ST_RUN) begin
         nxt_ovth = ov_track; // [R10]
      end else if (state_ff != ST_OFF && ov_track > ov_fixed) begin
         nxt_ovth = ov_track; // [R10]
      end
      nxt_clamp = clamp_ff;
      if (!bias_por_ok) begin
         nxt_clamp = 1'b0;
      end else if (feedback_above_ov) begin
         nxt_clamp = 1'b1; // [R9] [R11]
      end else if (feedback_below_hyst) begin
         nxt_clamp = 1'b0; // [R11] [R12]
      end
      nxt_drive = 1'b0;
      if (por_ok && !nxt_clamp) begin
         // pre-charged outputs wait for the ramp to pass them or for run
         nxt_drive = (state_ff == ST_RUN) || (state_ff == ST_RAMP && nxt_caught); // [R13] [R18] [R19]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_OFF;
         cyc_ff <= 4'h0;
         ref_ff <= 8'h00;
         caught_ff <= 1'b0;
         ovth_ff <= 9'h000;
         clamp_ff <= 1'b0;
         drive_ff <= 1'b0;
         gate_oe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cyc_ff <= nxt_cyc;
         ref_ff <= nxt_ref;
         caught_ff <= nxt_caught;
         ovth_ff <= nxt_ovth;
         clamp_ff <= nxt_clamp;
         drive_ff <= nxt_drive;
         gate_oe_ff <= nxt_gate_oe;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign pwm_enable = drive_ff;
   assign low_side_gate = clamp_ff;
   assign low_side_gate_oe = gate_oe_ff;
   assign reference_level = ref_ff;
   assign overvoltage_guard_level = ovth_ff;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_wait_last;
      state_ff == ST_WAIT && phase_edge && cyc_ff == 4'hF;
   endsequence

   sequence s_enter_ramp;
      state_ff == ST_RAMP;
   endsequence

   AST_ACCEPT: assert property ($changed(code_ff) |-> $past(same_ff) == 2'h1 && $past(samp_tick)) // [R3]
      else $error("code accepted without three equal samples");
   AST_WAIT16: assert property ($rose(state_ff == ST_RAMP) |-> // [R16]
      $past(state_ff) == ST_WAIT && $past(cyc_ff) == 4'hF)
      else $error("ramp started before sixteen phase cycles");
   AST_WAIT_GO: assert property (s_wait_last and start_ok |=> s_enter_ramp) // [R16]
      else $error("ramp did not start after the wait");
   AST_RAMP_STEP: assert property (state_ff == ST_RAMP && $past(state_ff) == ST_RAMP && // [R17]
      $changed(ref_ff) |-> ref_ff == $past(ref_ff) + 8'h01)
      else $error("ramp step is not one unit");
   AST_SIX_JUMP: assert property (state_ff == ST_RUN && six && start_ok |=> ref_ff == $past(target)) // [R6]
      else $error("six-bit reference did not follow the code");
   AST_FIVE_STEP: assert property (state_ff == ST_RUN && !six && $past(state_ff) == ST_RUN && // [R4]
      $past(!six) && $changed(ref_ff) |-> $past(phase_edge) && $past(cyc_ff) == 4'h3)
      else $error("five-bit step off the four-cycle grid");
   AST_POR_OFF: assert property (!por_ok |=> !drive_ff) // [R13]
      else $error("drivers on below power-on level");
   AST_TRISTATE: assert property (!bias_por_ok |=> !gate_oe_ff && !clamp_ff) // [R8]
      else $error("low-side drive active below power-on level");
   AST_OV_RUN: assert property (state_ff == ST_RUN |=> ovth_ff == {1'b0, $past(target)} + 9'h010) // [R10]
      else $error("run overvoltage level is not target plus margin");
   AST_CLAMP_HOLD: assert property (clamp_ff && bias_por_ok && !feedback_below_hyst |=> clamp_ff) // [R11]
      else $error("clamp released above hysteresis");
   AST_NO_LATCH: assert property (clamp_ff && bias_por_ok && feedback_below_hyst && !feedback_above_ov |=> // [R12]
      !clamp_ff)
      else $error("clamp latched after the event cleared");
   AST_NO_LOAD: assert property (no_load |=> state_ff == ST_OFF ##1 state_ff == ST_OFF || !no_load) // [R14]
      else $error("started on the no-load code");
   AST_PRECHARGE: assert property (state_ff == ST_RAMP && !caught_ff && feedback_above_ref |=> !drive_ff) // [R18]
      else $error("drivers on while feedback above ramp");
endmodule // vid_softstart_sequencer
`default_nettype wire

//--- vid_processor_model.sv
// Purpose: load processor model driving the identification pins
// Assumes: req_code is {code_select_pins, code_extra_bit}
// Notes:   six-bit mode walks one code step per 32 hclk cycles
`timescale 1ns/10ps
`default_nettype none
module vid_processor_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic six_mode,
   input wire logic [5:0] req_code,
   output logic [4:0] code_select_pins,
   output logic code_extra_bit
);
   logic [5:0] cur_ff;
   logic [4:0] hold_ff;
   assign {code_select_pins, code_extra_bit} = cur_ff;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_ff <= 6'h3F;
         hold_ff <= 5'h00;
      end else if (!six_mode) begin
         cur_ff <= req_code;
      end else begin
         hold_ff <= hold_ff + 5'h01;
         // held long enough for three readings before the next step
         if (hold_ff == 5'h1F && cur_ff < req_code) cur_ff <= cur_ff + 6'h01;
         else if (hold_ff == 5'h1F && cur_ff > req_code) cur_ff <= cur_ff - 6'h01;
      end
   end
endmodule // vid_processor_model
`default_nettype wire

//--- vid_softstart_sequencer_test.sv
// Purpose: self-checking bench of the sequencer
// Assumes: phase clock period of 16 hclk cycles
// Notes:   bus reads and reference steps are checked from queues
`timescale 1ns/10ps
`default_nettype none
`include "vss_regs.svh"
module vid_softstart_sequencer_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0, phase_clock = 1'b0, ph_d = 1'b0;
   logic bias_ok = 1'b0, drv_ok = 1'b0, en_in = 1'b0, fb_ref = 1'b1, fb_ov = 1'b0, fb_hyst = 1'b0;
   logic six_mode = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] ph_cnt = 4'h0;
   logic [5:0] req_code = 6'h3F;
   logic [7:0] ref_d = 8'h00, ua;
   logic [15:0] s;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, lfsr = 32'hE04FD3F0;
   logic [63:0] r;
   logic [63:0] rd_q[$];
   logic [15:0] ref_q[$];
   wire hreadyout, hresp, pwm_enable, low_side_gate, low_side_gate_oe, extra;
   wire [31:0] hrdata;
   wire [7:0] reference_level;
   wire [8:0] ov_level;
   wire [4:0] pins;
   int mismatches = 0, tests_run = 0, cycles = 0, gap = 0;

   vid_softstart_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .phase_clock(phase_clock), .code_select_pins(pins), .code_extra_bit(extra),
      .bias_por_ok(bias_ok), .driver_supply_por_ok(drv_ok), .threshold_enable_input(en_in),
      .feedback_above_ref(fb_ref), .feedback_above_ov(fb_ov), .feedback_below_hyst(fb_hyst),
      .pwm_enable(pwm_enable), .low_side_gate(low_side_gate), .low_side_gate_oe(low_side_gate_oe),
      .reference_level(reference_level), .overvoltage_guard_level(ov_level));
   vid_processor_model cpu (.hclk(hclk), .hresetn(hresetn), .six_mode(six_mode), .req_code(req_code),
      .code_select_pins(pins), .code_extra_bit(extra));

   always #25 hclk = ~hclk;
   always @(posedge hclk) begin
      ph_cnt <= ph_cnt + 4'h1;
      phase_clock <= ph_cnt[3];
   end

   // ***************************************************
   // tasks
   // ***************************************************
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic fin(input string n);
      $display("test %s finished", n);
   endtask
   // address phase held until hready, then data phase until hready again
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_pend <= !wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_pend <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rd_q.push_back({m, e});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic steps(input int lo, input int hi, input int by, input int gp);
      for (int v = lo; (by > 0) ? v <= hi : v >= hi; v += by)
         ref_q.push_back({(v == lo) ? 8'h00 : gp[7:0], v[7:0]});
   endtask
   task automatic wait_ref(input logic [7:0] v);
      // only reaching the level or the run timeout ends this wait
      while (reference_level !== v) @(posedge hclk);
      repeat (4) @(posedge hclk);
      #1;
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // ***************************************************
   // checking
   // ***************************************************
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         $display("CHECK FAILED at %0t: run timed out", $time);
         test_done();
      end
      if (rd_pend) begin
         r = rd_q.pop_front();
         chk(hrdata & r[63:32], r[31:0], "read data");
         chk(hresp, 32'h0, "response");
      end
      if (phase_clock && !ph_d) gap++;
      ph_d <= phase_clock;
      if (hresetn && reference_level !== ref_d) begin
         s = (ref_q.size() > 0) ? ref_q.pop_front() : {8'h00, ~ref_d};
         chk(reference_level, s[7:0], "reference"); // level steps
         if (s[15:8] != 8'h00) chk(gap, s[15:8], "phase cycles per step"); // step spacing
         gap = 0;
      end
      ref_d <= reference_level;
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      pause(4);
      chk(low_side_gate_oe, 32'h0, "gate enable"); // drivers floating
      chk(pwm_enable, 32'h0, "pwm"); // switches off
      chk(ov_level, `VSS_OV_FIXED_HIGH, "fixed level"); // five-bit threshold
      rd(`VSS_CONTROL_ADDR, `VSS_CONTROL_RESET, 32'h3);
      for (int i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         ua = 8'h0C + {lfsr[5:2], 2'h0};
         bus(1'b1, ua, lfsr);
         rd(ua, 32'h0, 32'hFFFFFFFF);
      end
      bus(1'b1, `VSS_CONTROL_ADDR, 32'h3);
      rd(`VSS_CONTROL_ADDR, `VSS_CONTROL_RESET, 32'h3);
      bus(1'b1, `VSS_CONTROL_ADDR, 32'h0);
      rd(`VSS_CONTROL_ADDR, 32'h0, 32'h3);
      pause(3);
      chk(ov_level, `VSS_OV_FIXED_LOW, "fixed level"); // alternate threshold
      fin("registers");
      bias_ok <= 1'b1;
      drv_ok <= 1'b1;
      en_in <= 1'b1;
      pause(200);
      chk(low_side_gate_oe, 32'h1, "gate enable"); // drivers active
      rd(`VSS_STATUS_ADDR, 32'h10, 32'h1F); // no load stays off
      fin("no load");
      steps(1, 64, 1, 16);
      req_code <= {5'h1E, 1'b0};
      wait_ref(8'h0A);
      chk(pwm_enable, 32'h0, "pwm"); // feedback above ramp
      chk(ov_level, `VSS_OV_FIXED_LOW, "ramp level"); // larger of the two
      fb_ref <= 1'b0;
      pause(4);
      chk(pwm_enable, 32'h1, "pwm"); // ramp passed feedback
      wait_ref(8'h40);
      chk(ov_level, 9'h040 + `VSS_OV_MARGIN, "run level"); // target plus margin
      rd(`VSS_LEVEL_ADDR, 32'h0050_4040, 32'hFFFFFFFF); // level word
      rd(`VSS_STATUS_ADDR, 32'h1A, 32'h1F); // started and running
      fin("soft start");
      req_code <= {5'h1E, 1'b1};
      pause(64);
      req_code <= {5'h00, 1'b0};
      @(posedge hclk);
      req_code <= {5'h1E, 1'b0};
      pause(64);
      steps(66, 72, 2, 4);
      req_code <= {5'h1A, 1'b0};
      wait_ref(8'h48);
      chk(ref_q.size(), 32'h0, "pending steps"); // stepped to target
      fin("five-bit change");
      steps(97, 95, -1, 0);
      six_mode <= 1'b1;
      bus(1'b1, `VSS_CONTROL_ADDR, 32'h2);
      req_code <= 6'h36;
      wait_ref(8'h5F);
      chk(ov_level, 9'h05F + `VSS_OV_MARGIN, "run level"); // six-bit jump
      fin("six-bit change");
      fb_ov <= 1'b1;
      pause(3);
      chk({low_side_gate, pwm_enable}, 32'h2, "clamp on"); // low sides on
      fb_ov <= 1'b0;
      pause(8);
      chk(low_side_gate, 32'h1, "clamp held"); // waits for hysteresis
      fb_hyst <= 1'b1;
      pause(3);
      chk({low_side_gate, pwm_enable}, 32'h1, "clamp off"); // not latched
      fb_hyst <= 1'b0;
      fb_ov <= 1'b1;
      pause(3);
      chk(low_side_gate, 32'h1, "clamp again"); // new excursion
      fb_ov <= 1'b0;
      fb_hyst <= 1'b1;
      pause(3);
      fb_hyst <= 1'b0;
      fin("overvoltage");
      ref_q.push_back(16'h0000);
      en_in <= 1'b0;
      wait_ref(8'h00);
      rd(`VSS_STATUS_ADDR, 32'h0, 32'h3); // enable lost
      steps(1, 95, 1, 16);
      fb_ref <= 1'b1;
      en_in <= 1'b1;
      wait_ref(8'h28);
      chk(pwm_enable, 32'h0, "pwm"); // pre-charged output
      wait_ref(8'h5F);
      chk(pwm_enable, 32'h1, "pwm"); // released at end of ramp
      fin("pre-charge");
      test_done();
   end
endmodule // vid_softstart_sequencer_test
`default_nettype wire
